// ==== logic/tcw_timer_defs.vh ====
// register map, field positions and reset values of the waveform timer block
`ifndef TCW_TIMER_DEFS_VH
`define TCW_TIMER_DEFS_VH

// block level map
`define TCW_CH_STRIDE    8'h40
`define TCW_BLK_CMD      8'hC0
`define TCW_BLK_MODE     8'hC4

// offsets inside one channel window
`define TCW_CH_CMD       6'h00
`define TCW_CH_MODE      6'h04
`define TCW_CH_CV        6'h10
`define TCW_CH_RA        6'h14
`define TCW_CH_RB        6'h18
`define TCW_CH_RC        6'h1C
`define TCW_CH_SR        6'h20
`define TCW_CH_IER       6'h24
`define TCW_CH_IDR       6'h28
`define TCW_CH_IMR       6'h2C

// command bits
`define TCW_CMD_CLKEN    0
`define TCW_CMD_CLKDIS   1
`define TCW_CMD_SOFT_TRIGGER_CMD    2
`define TCW_BCMD_SYNC    0

// channel mode fields
`define TCW_M_CLKSEL     2:0
`define TCW_M_CLKINV     3
`define TCW_M_BURST      5:4
`define TCW_M_CSTOP      6
`define TCW_M_CDIS       7
`define TCW_M_EVEDGE     9:8
`define TCW_M_EVSRC      11:10
`define TCW_M_EVTRG      12
`define TCW_M_PROFILE    14:13
`define TCW_M_WAVE       15
`define TCW_M_ACPA       17:16
`define TCW_M_ACPC       19:18
`define TCW_M_AEEV       21:20
`define TCW_M_ASW        23:22
`define TCW_M_BCPB       25:24
`define TCW_M_BCPC       27:26
`define TCW_M_BEEV       29:28
`define TCW_M_BSW        31:30

// status bits
`define TCW_SR_OVF       0
`define TCW_SR_CPA       2
`define TCW_SR_CPB       3
`define TCW_SR_CPC       4
`define TCW_SR_ETRG      7
`define TCW_SR_CLKSTA    16

// reset values
`define TCW_MODE_RST     32'h0000_0000
`define TCW_CMP_RST      16'h0000
`define TCW_BMODE_RST    6'h00
`define TCW_TOP_FULL     16'hFFFF

`endif

// ==== logic/tcw_timer_block.v ====
// three-channel 16-bit timer block in waveform mode with an apb register slave
`timescale 1ns/1ps
`default_nettype none
`include "tcw_timer_defs.vh"

// Overview of operation
// [R1] - waveform mode when the mode-register wave bit is one, capture otherwise; capture is not built here
// [R2] - waveform mode gives one or two pwm lines of one period, or pulses
// [R3] - line a is driven in waveform mode; line b unless it is the event source
// [R4] - compares a, b, c all act; a drives line a, b line b, c both
// [R5] - profile 00 counts zero to 0xFFFF, wraps to zero, repeats
// [R6] - profile 00: event or software trigger resets the counter at any time
// [R7] - profiles 00 and 01: compare c never triggers the counter
// [R8] - compare c stops and/or disables the counting clock when so enabled
// [R9] - profile 10 counts zero to compare c, resets on match, repeats
// [R10] - profile 10: event or software trigger resets the counter anytime
// [R11] - profile 01 counts up to 0xFFFF, down to zero, up again
// [R12] - profiles 01 and 11: a trigger reverses the count direction
// [R13] - profile 11 counts up to compare c, down to zero, up again
// [R14] - event source is line b or an xc clock, edge chosen; none means none
// [R15] - event source line b: line b released and compare b unused
// [R16] - external event triggers only with event trigger enable set
// [R17] - sync and software trigger always trigger; compare c per profile
// [R18] - set, clear or toggle lines per event as programmed
// [R19] - channels at 0x00, 0x40, 0x80; block command 0xC0, block mode 0xC4
// [R20] - compare a and b writes ignored in capture mode
// [R21] - block sync bit one triggers all channels at once; zero does nothing
// [R22] - software trigger resets the counter and starts the clock
// [R23] - any trigger takes effect at the next counting clock edge
// [R24] - xc source codes: 00 pin, 01 none, 10/11 other channels' line a
// [R25] - counters are 16 bits and advance only on counting clock edges
// [R26] - stopped or disabled counter holds value and direction until restart

module tcw_timer_block #(
  parameter [79:0] PRESCALE = {16'd1024, 16'd128, 16'd32, 16'd8, 16'd2}
) (
  // clock, reset, clock enable
  input  wire        clk,
  input  wire        reset_n,
  input  wire        ce,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  // external clock pins
  input  wire [2:0]  ext_clock_pin,
  // channel lines, one bit per channel
  input  wire [2:0]  line_a_in,
  output wire [2:0]  line_a_out,
  output wire [2:0]  line_a_oe,
  input  wire [2:0]  line_b_in,
  output wire [2:0]  line_b_out,
  output wire [2:0]  line_b_oe
);

  // zero wait states: data is prepared in the setup cycle
  assign pready = 1'b1;

  wire        acc_wr = psel & penable & pwrite;
  wire        acc_rd = psel & penable & ~pwrite;
  wire [1:0]  ch_idx = paddr[7:6];
  wire [5:0]  ch_off = paddr[5:0];

  // pin synchronisers: three stages, change taken when stages 2 and 3 agree
  reg  [5:0] sy1;
  reg  [5:0] sy2;
  reg  [5:0] sy3;
  reg  [5:0] pin_f;
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      sy1   <= 6'h00;
      sy2   <= 6'h00;
      sy3   <= 6'h00;
      pin_f <= 6'h00;
    end
    else if (ce)
    begin
      sy1   <= {line_b_in, ext_clock_pin};
      sy2   <= sy1;
      sy3   <= sy2;
      pin_f <= (sy2 & sy3) | (pin_f & (sy2 ^ sy3));
    end
  end
  wire [2:0] clk_pin_f = pin_f[2:0];
  wire [2:0] line_b_f  = pin_f[5:3];

  // line a has no consumer while capture is not built here
  wire unused_in = ^line_a_in;

  // block registers
  reg  [5:0] blk_mode;
  wire       sync_pulse = acc_wr && paddr == `TCW_BLK_CMD
                          && pwdata[`TCW_BCMD_SYNC]; // [R21]
  always @(posedge clk)
  begin
    if (!reset_n)
      blk_mode <= `TCW_BMODE_RST;
    else if (ce && acc_wr && paddr == `TCW_BLK_MODE) // [R19]
      blk_mode <= pwdata[5:0];
  end

  // internal counting clocks from a divider per tap
  wire [4:0] pre_tick;
  // external clock sources xc0..xc2
  wire [2:0] xc;
  wire [95:0] rd_ch;
  genvar k;
  generate
    for (k = 0; k < 5; k = k + 1)
    begin : g_pre
      reg  [15:0] pcnt;
      wire [15:0] plast = PRESCALE[k*16 +: 16] - 16'd1;
      assign pre_tick[k] = (pcnt == plast);
      always @(posedge clk)
      begin
        if (!reset_n)
          pcnt <= 16'h0000;
        else if (ce)
          pcnt <= pre_tick[k] ? 16'h0000 : pcnt + 16'd1;
      end
    end
    for (k = 0; k < 3; k = k + 1)
    begin : g_xc
      localparam integer O1 = (k == 0) ? 1 : 0;
      localparam integer O2 = (k == 2) ? 1 : 2;
      wire [1:0] s = blk_mode[k*2 +: 2];
      assign xc[k] = (s == 2'b00) ? clk_pin_f[k] :
                     (s == 2'b10) ? line_a_out[O1] :
                     (s == 2'b11) ? line_a_out[O2] : 1'b0; // [R24]
    end
  endgenerate

  // output action: 00 none, 01 set, 10 clear, 11 toggle
  function act;
    input       cur;
    input [1:0] a;
    begin
      case (a)
        2'b01:   act = 1'b1;
        2'b10:   act = 1'b0;
        2'b11:   act = ~cur;
        default: act = cur;
      endcase
    end
  endfunction

  generate
    for (k = 0; k < 3; k = k + 1)
    begin : g_ch
      reg  [31:0] mode;
      reg  [15:0] cv;
      reg  [15:0] ra;
      reg  [15:0] rb;
      reg  [15:0] rc;
      reg  [7:0]  sticky;
      reg  [7:0]  imask;
      reg         dir_down;
      reg         clk_en;
      reg         started;
      reg         trg_pend;
      reg         chk;
      reg         src_prev;
      reg         ev_prev;
      reg         la;
      reg         lb;
      reg         next_la;
      reg         next_lb;
      reg  [31:0] rd;

      // a genvar cannot be part-selected, so its index is held at two bits here
      localparam [1:0] CH_ID = k;
      wire sel = (ch_idx == CH_ID);
      wire wr  = acc_wr & sel;
      wire wave = mode[`TCW_M_WAVE]; // [R1]
      wire [1:0] prof = mode[`TCW_M_PROFILE];
      wire updown = prof[0];
      wire [15:0] top = prof[1] ? rc : `TCW_TOP_FULL;

      // counting clock: internal tap or xc edge, optionally inverted and gated
      wire [2:0] csel = mode[`TCW_M_CLKSEL];
      wire [1:0] bsel = mode[`TCW_M_BURST];
      wire src_lvl = (csel == 3'd5) ? xc[0] :
                     (csel == 3'd6) ? xc[1] : xc[2];
      wire src_cur = src_lvl ^ mode[`TCW_M_CLKINV];
      wire gate = (bsel == 2'b00) ? 1'b1 : xc[bsel - 2'd1];
      wire raw_tick = (csel < 3'd5) ? pre_tick[csel] : (src_cur & ~src_prev);
      wire tick = raw_tick & gate;

      // external event selection and edge detection
      wire [1:0] esrc = mode[`TCW_M_EVSRC];
      wire [1:0] eedg = mode[`TCW_M_EVEDGE];
      wire b_is_event = (esrc == 2'b00);
      wire ev_lvl = b_is_event ? line_b_f[k] : xc[esrc - 2'd1];
      wire ext_ev = ((eedg[0] & ev_lvl & ~ev_prev) |
                     (eedg[1] & ~ev_lvl & ev_prev)); // [R14]

      // commands
      wire cmd_wr = wr && ch_off == `TCW_CH_CMD;
      wire c_en   = cmd_wr & pwdata[`TCW_CMD_CLKEN] & ~pwdata[`TCW_CMD_CLKDIS];
      wire c_dis  = cmd_wr & pwdata[`TCW_CMD_CLKDIS];
      wire sw     = (cmd_wr & pwdata[`TCW_CMD_SOFT_TRIGGER_CMD]) | sync_pulse; // [R17] [R22]

      // compare events, one cycle after the counter moved
      wire a_ev = chk & wave & (cv == ra); // [R4]
      wire b_ev = chk & wave & (cv == rb) & ~b_is_event; // [R15]
      wire c_ev = chk & wave & (cv == rc);

      // compare c is never a trigger; profile 10 resets through the count step
      wire trig = sw | (ext_ev & mode[`TCW_M_EVTRG]); // [R7] [R16]
      wire run  = clk_en & started;
      wire step = tick & (run | trg_pend); // [R25]

      wire [7:0] set_v = {ext_ev, 2'b00, c_ev, b_ev, a_ev, 1'b0,
                          step & ~trg_pend & ~updown & (cv == 16'hFFFF)};
      wire rd_sr = acc_rd && sel && ch_off == `TCW_CH_SR;

      always @*
      begin
        next_la = la;
        next_lb = lb;
        if (a_ev)
          next_la = act(next_la, mode[`TCW_M_ACPA]); // [R18]
        if (c_ev)
          next_la = act(next_la, mode[`TCW_M_ACPC]);
        if (ext_ev)
          next_la = act(next_la, mode[`TCW_M_AEEV]);
        if (sw)
          next_la = act(next_la, mode[`TCW_M_ASW]);
        if (b_ev)
          next_lb = act(next_lb, mode[`TCW_M_BCPB]);
        if (c_ev)
          next_lb = act(next_lb, mode[`TCW_M_BCPC]);
        if (ext_ev)
          next_lb = act(next_lb, mode[`TCW_M_BEEV]);
        if (sw)
          next_lb = act(next_lb, mode[`TCW_M_BSW]);
      end

      always @(posedge clk)
      begin
        if (!reset_n)
        begin
          mode     <= `TCW_MODE_RST;
          cv       <= 16'h0000;
          ra       <= `TCW_CMP_RST;
          rb       <= `TCW_CMP_RST;
          rc       <= `TCW_CMP_RST;
          sticky   <= 8'h00;
          imask    <= 8'h00;
          dir_down <= 1'b0;
          clk_en   <= 1'b0;
          started  <= 1'b0;
          trg_pend <= 1'b0;
          chk      <= 1'b0;
          src_prev <= 1'b0;
          ev_prev  <= 1'b0;
          la       <= 1'b0;
          lb       <= 1'b0;
        end
        else if (ce)
        begin
          src_prev <= src_cur;
          ev_prev  <= ev_lvl;
          chk      <= step;
          // register writes
          if (wr && ch_off == `TCW_CH_MODE)
            mode <= pwdata;
          if (wr && wave && ch_off == `TCW_CH_RA) // [R20]
            ra <= pwdata[15:0];
          if (wr && wave && ch_off == `TCW_CH_RB) // [R20]
            rb <= pwdata[15:0];
          if (wr && ch_off == `TCW_CH_RC)
            rc <= pwdata[15:0];
          if (wr && ch_off == `TCW_CH_IER)
            imask <= imask | pwdata[7:0];
          else if (wr && ch_off == `TCW_CH_IDR)
            imask <= imask & ~pwdata[7:0];
          // read clears only what was returned, so a new event is never lost
          sticky <= (sticky & ~(rd_sr ? prdata[7:0] : 8'h00)) | set_v;
          // clock control
          if (c_dis || (c_ev && mode[`TCW_M_CDIS])) // [R8]
          begin
            clk_en   <= 1'b0;
            started  <= 1'b0;
            trg_pend <= 1'b0;
          end
          else if (c_en) // [R26]
          begin
            clk_en  <= 1'b1;
            started <= 1'b1;
            if (trig)
              trg_pend <= 1'b1;
          end
          else
          begin
            // a trigger arriving with the tick waits for the next tick
            if (clk_en && trig) // [R23]
            begin
              started  <= 1'b1;
              trg_pend <= 1'b1;
            end
            else
            begin
              if (c_ev && mode[`TCW_M_CSTOP]) // [R8]
                started <= 1'b0;
              if (tick)
                trg_pend <= 1'b0;
            end
          end
          // counter step; holds while stopped or disabled
          if (step) // [R26]
          begin
            if (trg_pend)
            begin
              cv <= 16'h0000; // [R6] [R10] [R22]
              if (updown)
                dir_down <= ~dir_down; // [R12]
            end
            else if (!updown)
            begin
              dir_down <= 1'b0;
              if (cv == top)
                cv <= 16'h0000; // [R5] [R9]
              else
                cv <= cv + 16'd1;
            end
            else if (!dir_down)
            begin
              if (cv >= top) // [R11] [R13]
              begin
                dir_down <= 1'b1;
                cv       <= (cv == 16'h0000) ? cv : cv - 16'd1;
              end
              else
                cv <= cv + 16'd1;
            end
            else
            begin
              if (cv == 16'h0000)
              begin
                dir_down <= 1'b0;
                cv       <= (top == 16'h0000) ? cv : 16'd1;
              end
              else
                cv <= cv - 16'd1;
            end
          end
          // output lines follow the programmed actions only in waveform mode
          if (wave) // [R2]
          begin
            la <= next_la;
            lb <= next_lb;
          end
        end
      end

      assign line_a_out[k] = la;
      assign line_b_out[k] = lb;
      assign line_a_oe[k]  = wave; // [R3]
      assign line_b_oe[k]  = wave & ~b_is_event; // [R3] [R15]

      always @*
      begin
        case (ch_off)
          `TCW_CH_MODE: rd = mode;
          `TCW_CH_CV:   rd = {16'h0000, cv};
          `TCW_CH_RA:   rd = {16'h0000, ra};
          `TCW_CH_RB:   rd = {16'h0000, rb};
          `TCW_CH_RC:   rd = {16'h0000, rc};
          `TCW_CH_SR:   rd = {15'h0000, clk_en, 8'h00, sticky};
          `TCW_CH_IMR:  rd = {24'h000000, imask};
          default:      rd = 32'h0000_0000;
        endcase
      end
      assign rd_ch[k*32 +: 32] = rd;
    end
  endgenerate

  // address decode: known offsets answer, everything else errors
  reg        hit;
  reg [31:0] rd_mux;
  always @*
  begin
    hit    = 1'b0;
    rd_mux = 32'h0000_0000;
    if (ch_idx == 2'd3)
    begin
      hit    = (paddr == `TCW_BLK_CMD) || (paddr == `TCW_BLK_MODE); // [R19]
      rd_mux = (paddr == `TCW_BLK_MODE) ? {26'h0000000, blk_mode} : 32'h0000_0000;
    end
    else
    begin
      case (ch_off)
        `TCW_CH_CMD, `TCW_CH_MODE, `TCW_CH_CV, `TCW_CH_RA, `TCW_CH_RB,
        `TCW_CH_RC, `TCW_CH_SR, `TCW_CH_IER, `TCW_CH_IDR, `TCW_CH_IMR:
          hit = 1'b1;
        default:
          hit = 1'b0;
      endcase
      rd_mux = rd_ch[ch_idx*32 +: 32];
    end
  end

  // read data is latched in the setup cycle and stands through the access
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      if (psel && !penable)
      begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= ~hit | unused_in & 1'b0;
      end
    end
  end

endmodule // tcw_timer_block

`default_nettype wire

// ==== verif/tcw_timer_chk.sv ====
// port-level assertion checker for the waveform timer block
`timescale 1ns/1ps
`default_nettype none
module tcw_timer_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        ce,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // line enables
  input wire logic [2:0]  line_a_oe,
  input wire logic [2:0]  line_b_oe
);
  logic [31:0] mode [3];
  logic [15:0] cmp_a [3];
  logic [1:0]  ch;
  logic [5:0]  off;
  logic        acc;
  logic        rdx;
  logic        bad;
  logic        wo;
  assign ch  = paddr[7:6];
  assign off = paddr[5:0];
  assign acc = psel && penable && ce && paddr[1:0] == 2'h0;
  assign rdx = acc && !pwrite && ch != 2'h3;
  assign bad = (ch == 2'h3) ? off > 6'h04 : (off == 6'h08 || off == 6'h0C || off > 6'h2C);
  assign wo  = (ch == 2'h3) ? off == 6'h00 : (off == 6'h00 || off == 6'h24 || off == 6'h28);
  // shadow copies taken at the access edge, where a write lands
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      mode  <= '{3{32'h0}};
      cmp_a <= '{3{16'h0}};
    end
    else if (acc && pwrite && ch != 2'h3)
    begin
      if (off == 6'h04)
        mode[ch] <= pwdata;
      if (off == 6'h14 && mode[ch][15])
        cmp_a[ch] <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  map_err_a: assert property (acc && bad |-> pslverr)
    else $error("no error on unmapped access");
  map_ok_a: assert property (acc && !bad |-> !pslverr)
    else $error("error on mapped access");
  wo_zero_a: assert property (acc && !pwrite && wo |-> prdata == 32'h0)
    else $error("write-only place read nonzero");
  mode_rb_a: assert property (rdx && off == 6'h04 |-> prdata == mode[ch])
    else $error("mode readback wrong");
  cmp_guard_a: assert property (rdx && off == 6'h14 |-> prdata == {16'h0, cmp_a[ch]})
    else $error("compare a guard wrong");
  cnt_width_a: assert property (rdx && off == 6'h10 |-> prdata[31:16] == 16'h0)
    else $error("counter wider than 16 bits");
  line_a_dir_a: assert property (line_a_oe == {mode[2][15], mode[1][15], mode[0][15]})
    else $error("line a direction wrong");
  line_b_dir_a: assert property (line_b_oe == {mode[2][15] && mode[2][11:10] != 2'h0,
    mode[1][15] && mode[1][11:10] != 2'h0, mode[0][15] && mode[0][11:10] != 2'h0})
    else $error("line b direction wrong");
  reset_out_a: assert property ($rose(reset_n) |-> line_a_oe == 3'h0 && prdata == 32'h0)
    else $error("outputs not cleared by reset");
  cover property (acc && pwrite && off == 6'h14 && ch != 2'h3 && !mode[ch][15]);
  cover property (acc && bad);
  cover property (line_b_oe[0]);
endmodule // tcw_timer_chk
bind tcw_timer_block tcw_timer_chk u_chk (
  .clk(clk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .line_a_oe(line_a_oe), .line_b_oe(line_b_oe)
);
`default_nettype wire

// ==== verif/tcw_timer_block_test.sv ====
// self-checking bench for the waveform timer block
`timescale 1ns/1ps
`default_nettype none
module tcw_timer_block_test;
  localparam logic [31:0] WAVE = 32'h0000_8000;
  logic        clk = 1'h0;
  logic        reset_n = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  line_b_in = 3'h0;
  logic [31:0] rd;
  logic        err;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [2:0]  la_out;
  wire  [2:0]  lb_out;
  int          miscompares = 0;
  int          n_tests = 0;
  always #5 clk = ~clk;
  tcw_timer_block u_dut (
    .clk(clk), .reset_n(reset_n), .ce(1'h1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clock_pin(3'h0), .line_a_in(3'h0), .line_a_out(la_out),
    .line_a_oe(), .line_b_in(line_b_in), .line_b_out(lb_out), .line_b_oe()
  );
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // entered just after an edge; psel stays up so another transfer may follow at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (pready === 1'h1)
        break;
    end
    rd = prdata;
    err = pslverr;
    penable <= 1'h0;
    if (i == 50)
    begin
      miscompares++;
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rel();
    psel <= 1'h0;
    @(posedge clk);
    @(posedge clk);
  endtask
  task automatic t_reset();
    logic [5:0] offs [7] = '{6'h04, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h2C};
    for (int c = 0; c < 3; c++)
      for (int k = 0; k < 7; k++)
      begin
        apb(1'h0, {c[1:0], offs[k]}, 32'h0);
        chk(rd, 32'h0);
      end
    apb(1'h0, 8'hC4, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 8'h00, 32'h0);
    chk(err, 1'h0);
    apb(1'h0, 8'h08, 32'h0);
    chk(err, 1'h1);
    rel();
    $display("t_reset done");
  endtask
  task automatic t_map();
    for (int c = 0; c < 3; c++)
      wr({c[1:0], 6'h04}, {16'h00A5, 6'h00, c[1:0], 8'h00});
    for (int c = 0; c < 3; c++)
    begin
      apb(1'h0, {c[1:0], 6'h04}, 32'h0);
      chk(rd, {16'h00A5, 6'h00, c[1:0], 8'h00});
    end
    wr(8'hC4, 32'h0000_0036);
    apb(1'h0, 8'hC4, 32'h0);
    chk(rd, 32'h0000_0036);
    wr(8'hC4, 32'h0);
    rel();
    $display("t_map done");
  endtask
  task automatic t_guard();
    wr(8'h44, 32'h0);
    wr(8'h54, 32'h1234);
    wr(8'h58, 32'h4321);
    apb(1'h0, 8'h54, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 8'h58, 32'h0);
    chk(rd, 32'h0);
    wr(8'h44, WAVE);
    wr(8'h54, 32'h1234);
    apb(1'h0, 8'h54, 32'h0);
    chk(rd, 32'h1234);
    rel();
    $display("t_guard done");
  endtask
  task automatic t_profile(input logic [31:0] m, input logic updn);
    logic [31:0] mx;
    logic [31:0] prev;
    logic        dn;
    mx = 32'h0;
    prev = 32'h0;
    dn = 1'h0;
    wr(8'h1C, 32'h5);
    wr(8'h04, m);
    wr(8'h00, 32'h1);
    // reads two cycles apart meet every value of a tap-by-2 count
    for (int i = 0; i < 40; i++)
    begin
      apb(1'h0, 8'h10, 32'h0);
      chk(rd <= 32'h5, 32'h1);
      if (rd > mx)
        mx = rd;
      if (prev == rd + 32'h1)
        dn = 1'h1;
      prev = rd;
    end
    chk(mx, 32'h5);
    chk(dn, updn);
    rel();
    $display("t_profile done");
  endtask
  task automatic t_trig();
    wr(8'h04, WAVE);
    for (int i = 0; i < 12; i++)
      apb(1'h0, 8'h10, 32'h0);
    chk(rd > 32'h8, 32'h1);
    wr(8'h00, 32'h4);
    rel();
    apb(1'h0, 8'h10, 32'h0);
    chk(rd < 32'h6, 32'h1);
    wr(8'h40, 32'h1);
    wr(8'h80, 32'h1);
    for (int i = 0; i < 12; i++)
      apb(1'h0, 8'h90, 32'h0);
    wr(8'hC0, 32'h0);
    apb(1'h0, 8'h90, 32'h0);
    chk(rd > 32'h8, 32'h1);
    wr(8'hC0, 32'h1);
    rel();
    apb(1'h0, 8'h50, 32'h0);
    chk(rd < 32'h6, 32'h1);
    apb(1'h0, 8'h90, 32'h0);
    chk(rd < 32'h6, 32'h1);
    rel();
    $display("t_trig done");
  endtask
  task automatic t_stop();
    logic [31:0] r1;
    wr(8'h04, WAVE | 32'h40);
    wr(8'h00, 32'h4);
    for (int i = 0; i < 12; i++)
      apb(1'h0, 8'h10, 32'h0);
    r1 = rd;
    apb(1'h0, 8'h10, 32'h0);
    chk(rd, r1);
    chk(rd >= 32'h5 && rd <= 32'h6, 32'h1);
    wr(8'h04, WAVE | 32'h80);
    wr(8'h00, 32'h4);
    for (int i = 0; i < 12; i++)
      apb(1'h0, 8'h20, 32'h0);
    chk(rd[16], 1'h0);
    rel();
    $display("t_stop done");
  endtask
  task automatic t_lines();
    logic [1:0] code [4] = '{2'h1, 2'h3, 2'h3, 2'h2};
    logic       exp [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
    wr(8'h00, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h04, WAVE | 32'h400 | {code[i], 6'h00, code[i], 22'h0});
      wr(8'h00, 32'h4);
      rel();
      chk(la_out[0], exp[i]);
      chk(lb_out[0], exp[i]);
    end
    $display("t_lines done");
  endtask
  task automatic t_event();
    wr(8'h04, WAVE | 32'h0010_1000);
    line_b_in <= 3'h1;
    repeat (8) rel();
    line_b_in <= 3'h0;
    repeat (8) rel();
    chk(la_out[0], 1'h0);
    apb(1'h0, 8'h10, 32'h0);
    chk(rd > 32'h8, 32'h1);
    wr(8'h04, WAVE | 32'h0010_1100);
    line_b_in <= 3'h1;
    repeat (4) rel();
    chk(la_out[0], 1'h1);
    apb(1'h0, 8'h10, 32'h0);
    chk(rd < 32'h8, 32'h1);
    rel();
    $display("t_event done");
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    t_reset();
    t_map();
    t_guard();
    t_profile(WAVE | 32'h4000, 1'h0);
    t_profile(WAVE | 32'h6000, 1'h1);
    t_trig();
    t_stop();
    t_lines();
    t_event();
    results();
  end
endmodule // tcw_timer_block_test
`default_nettype wire
